/* rtl/can_bit_timing_sync.sv */
// Bit timing engine: quantum, segments, sampling and bus synchronisation
// What this block does
// R1: Segments and bit are whole quanta; a bit is 8 to 25 quanta.
// R2: Software keeps the nominal bit at one microsecond or longer.
// R3: Quantum is two times prescale field plus one module clocks.
// R4: Propagation segment is 1 to 8 quanta from config 2 bits 2..0.
// R5: Phase 1 is 1 to 8 quanta, bits 5..3; sample at its end.
// R6: Phase 2 is programmed, bits 10..8, or max of phase 1 and 2.
// R7: Software keeps propagation plus phase 1 not below phase 2.
// R8: Bit 6 set takes majority of three samples half a quantum apart.
// R9: Software places the sample point near 60 to 70 percent.
// R10: A bus edge adjusts phase 1 and phase 2 from its position.
// R11: Hard sync on falling edge while idle restarts at sync segment.
// R12: No resynchronisation in a bit that saw a hard sync.
// R13: Resync moves phase segments by at most jump width, 1 to 4.
// R14: Software keeps phase 2 longer than the jump width.
// R15: All nodes share bit rate and length by choosing quanta counts.
// R16: Sync segment is one quantum; each field encodes value plus one.
// R17: A config bit picks programmed or derived phase 2 length.
`timescale 1ns/1ps
module can_bit_timing_sync (
    // Clock, reset, enable
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    // Timing configuration words
    input  wire logic [15:0]         timing_config_1,
    input  wire logic [15:0]         timing_config_2,
    // Bus side
    input  wire logic                rx_in,
    input  wire logic                bus_idle,
    // Status toward the protocol logic
    output can_bt_pkg::bit_status_t  status
);
    import can_bt_pkg::*;

    // ==================================================
    // Configuration decode
    // ==================================================
    timing_cfg_t cfg;
    len_t        prop_len;
    len_t        ph1_base;
    len_t        ph2_prog;
    len_t        ph2_auto;
    len_t        ph2_base;
    len_t        sjw_len;
    len_t        nominal_len;
    logic        run_ok;

    // Field extraction from the two configuration words
    always_comb begin
        cfg.quantum_prescale  = timing_config_1[PRESCALE_LSB +: PRESCALE_W];
        cfg.sync_jump_width   = timing_config_1[SJW_LSB +: SJW_W];
        cfg.prop_seg_len      = timing_config_2[PROP_LSB +: SEG_FIELD_W];
        cfg.phase1_len        = timing_config_2[PH1_LSB +: SEG_FIELD_W];
        cfg.phase2_len        = timing_config_2[PH2_LSB +: SEG_FIELD_W];
        cfg.triple_sample_sel = timing_config_2[TRIPLE_BIT];
        cfg.phase2_auto_sel   = timing_config_2[PH2_AUTO_BIT];
    end

    // Lengths in quanta, field value plus one
    assign prop_len = len_t'(cfg.prop_seg_len) + 5'h01;      // [R4] [R16]
    assign ph1_base = len_t'(cfg.phase1_len) + 5'h01;        // [R5] [R16]
    assign ph2_prog = len_t'(cfg.phase2_len) + 5'h01;        // [R6] [R16]
    assign sjw_len  = len_t'(cfg.sync_jump_width) + 5'h01;   // [R13]
    assign ph2_auto = (ph1_base > PROC_TIME_TQ) ? ph1_base : PROC_TIME_TQ; // [R6]
    assign ph2_base = cfg.phase2_auto_sel ? ph2_auto : ph2_prog;          // [R17]

    // Too short a bit is refused; the longest fields give exactly 25
    assign nominal_len = SYNC_SEG_TQ + prop_len + ph1_base + ph2_base;
    assign run_ok      = (nominal_len >= MIN_BIT_TQ);        // [R1]

    // ==================================================
    // Quantum generation
    // ==================================================
    logic half_tick;
    logic tq_tick;
    logic restart;

    tq_prescaler #(
        .PRESCALE_W (PRESCALE_W)
    ) u_prescaler (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .ce        (ce),
        .prescale  (cfg.quantum_prescale),
        .restart   (restart),
        .half_tick (half_tick),
        .tq_tick   (tq_tick)
    );

    // ==================================================
    // Segment sequencing
    // ==================================================
    seg_state_t seg_reg;
    len_t       tq_cnt_reg;
    len_t       ph1_ext_reg;
    len_t       ph2_cut_reg;
    logic       hsync_bit_reg;
    logic       resync_done_reg;
    logic       prev_rx_reg;
    len_t       ph1_eff;
    len_t       ph2_eff;
    len_t       seg_len;
    logic       seg_end;
    logic       bit_wrap;

    assign ph1_eff = ph1_base + ph1_ext_reg;                 // [R13]
    assign ph2_eff = ph2_base - ph2_cut_reg;                 // [R13]

    // Length of the segment in progress
    always_comb begin
        case (seg_reg)
            SEG_SYNC: seg_len = SYNC_SEG_TQ;                 // [R16]
            SEG_PROP: seg_len = prop_len;
            SEG_PH1:  seg_len = ph1_eff;
            SEG_PH2:  seg_len = ph2_eff;
            default:  seg_len = SYNC_SEG_TQ;
        endcase
    end

    assign seg_end  = tq_tick && (tq_cnt_reg == seg_len - 5'h01); // [R1]
    assign bit_wrap = seg_end && (seg_reg == SEG_PH2);

    // ==================================================
    // Edge classification
    // ==================================================
    logic edge_fall;
    logic hard_sync_now;
    logic resync_cand;
    logic resync_late;
    logic resync_early;
    logic early_restart;
    len_t late_err;
    len_t early_rem;

    // Only recessive to dominant transitions synchronise
    assign edge_fall     = ce && run_ok && (prev_rx_reg == RECESSIVE) && (rx_in != RECESSIVE);
    assign hard_sync_now = edge_fall && bus_idle;            // [R11]
    assign resync_cand   = edge_fall && !bus_idle && !hsync_bit_reg  // [R12]
                           && !resync_done_reg && (seg_reg != SEG_SYNC);
    assign resync_late   = resync_cand && (seg_reg == SEG_PROP || seg_reg == SEG_PH1);
    assign resync_early  = resync_cand && (seg_reg == SEG_PH2);

    // Phase error in quanta: late edges from the end of the sync segment, early ones to the end of phase 2
    assign late_err  = (seg_reg == SEG_PROP) ? (tq_cnt_reg + 5'h01)
                                             : (prop_len + tq_cnt_reg + 5'h01); // [R10]
    assign early_rem = ph2_eff - tq_cnt_reg;                 // [R10]

    // An early edge within the jump width simply starts the next bit
    assign early_restart = resync_early && (early_rem <= sjw_len); // [R13]
    assign restart       = hard_sync_now || early_restart;   // [R11]

    // Segment state and quantum count within the segment
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            seg_reg    <= SEG_SYNC;
            tq_cnt_reg <= '0;
        end else if (ce) begin
            if (!run_ok || restart) begin
                seg_reg    <= SEG_SYNC;                      // [R11]
                tq_cnt_reg <= '0;
            end else if (seg_end) begin
                tq_cnt_reg <= '0;
                case (seg_reg)
                    SEG_SYNC: seg_reg <= SEG_PROP;
                    SEG_PROP: seg_reg <= SEG_PH1;
                    SEG_PH1:  seg_reg <= SEG_PH2;
                    SEG_PH2:  seg_reg <= SEG_SYNC;
                    default:  seg_reg <= SEG_SYNC;
                endcase
            end else if (tq_tick) begin
                tq_cnt_reg <= tq_cnt_reg + 5'h01;
            end
        end
    end

    // Phase adjustments and per-bit sync bookkeeping
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ph1_ext_reg     <= '0;
            ph2_cut_reg     <= '0;
            hsync_bit_reg   <= 1'b0;
            resync_done_reg <= 1'b0;
        end else if (ce) begin
            if (!run_ok || bit_wrap || restart) begin
                ph1_ext_reg     <= '0;
                ph2_cut_reg     <= '0;
                hsync_bit_reg   <= hard_sync_now;            // [R12]
                resync_done_reg <= 1'b0;
            end else if (resync_late) begin
                ph1_ext_reg     <= (late_err < sjw_len) ? late_err : sjw_len; // [R10] [R13]
                resync_done_reg <= 1'b1;
            end else if (resync_early) begin
                ph2_cut_reg     <= sjw_len;                  // [R10] [R13]
                resync_done_reg <= 1'b1;
            end
        end
    end

    // Previous bus level for edge detection
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            prev_rx_reg <= RECESSIVE;
        end else if (ce) begin
            prev_rx_reg <= rx_in;
        end
    end

    // ==================================================
    // Sampling
    // ==================================================
    logic [1:0] samp_reg;
    logic       sample_now;
    logic       majority;
    logic       rx_bit_reg;

    assign sample_now = seg_end && (seg_reg == SEG_PH1) && !restart; // [R5]
    assign majority   = (rx_in & samp_reg[0]) | (rx_in & samp_reg[1])
                        | (samp_reg[0] & samp_reg[1]);       // [R8]

    // Early samples, one and two half quanta before the current point
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            samp_reg <= {2{RECESSIVE}};
        end else if (ce && half_tick) begin
            samp_reg <= {samp_reg[0], rx_in};                // [R8]
        end
    end

    // Received bit value, recessive until the first sample
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rx_bit_reg <= RECESSIVE;
        end else if (ce && sample_now) begin
            rx_bit_reg <= cfg.triple_sample_sel ? majority : rx_in; // [R8]
        end
    end

    // ==================================================
    // Status pulses
    // ==================================================
    logic quantum_pulse_reg;
    logic sample_pulse_reg;
    logic bit_start_reg;
    logic hard_sync_reg;
    logic resync_reg;

    // Registered one-cycle strobes; held while ce is low
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            quantum_pulse_reg <= 1'b0;
            sample_pulse_reg  <= 1'b0;
            bit_start_reg     <= 1'b0;
            hard_sync_reg     <= 1'b0;
            resync_reg        <= 1'b0;
        end else if (ce) begin
            quantum_pulse_reg <= tq_tick;
            sample_pulse_reg  <= sample_now;
            bit_start_reg     <= bit_wrap || restart;
            hard_sync_reg     <= hard_sync_now;
            resync_reg        <= resync_late || resync_early;
        end
    end

    always_comb begin
        status.seg           = seg_reg;
        status.rx_bit        = rx_bit_reg;
        status.quantum_pulse = quantum_pulse_reg;
        status.sample_pulse  = sample_pulse_reg;
        status.bit_start     = bit_start_reg;
        status.hard_sync     = hard_sync_reg;
        status.resync        = resync_reg;
        status.cfg_error     = !run_ok;
    end

    // ==================================================
    // Checks
    // ==================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    len_t        bit_tq_reg;
    logic        bit_clean_reg;
    logic [31:0] cfg_seen_reg;

    // Quanta per bit over bits without any sync event or config change
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            bit_tq_reg    <= '0;
            bit_clean_reg <= 1'b0;
            cfg_seen_reg  <= '0;
        end else begin
            cfg_seen_reg <= {timing_config_1, timing_config_2};
            if (!ce || restart || resync_cand
                    || cfg_seen_reg != {timing_config_1, timing_config_2}) begin
                bit_tq_reg    <= '0;
                bit_clean_reg <= 1'b0;
            end else if (bit_wrap) begin
                bit_tq_reg    <= '0;
                bit_clean_reg <= 1'b1;
            end else if (tq_tick) begin
                bit_tq_reg    <= bit_tq_reg + 5'h01;
            end
        end
    end

    a_bit_length: assert property ( // [R1]
        (bit_wrap && bit_clean_reg) |-> (bit_tq_reg + 5'h01 == nominal_len
                                         && nominal_len >= MIN_BIT_TQ
                                         && nominal_len <= MAX_BIT_TQ)
    ) else $error("clean bit length differs from configured quanta");

    a_sync_one_tq: assert property ( // [R16]
        (ce && run_ok && !restart && tq_tick && seg_reg == SEG_SYNC) |=> (seg_reg == SEG_PROP)
    ) else $error("sync segment lasted more than one quantum");

    a_prop_length: assert property ( // [R4]
        (ce && !restart && tq_tick && seg_reg == SEG_PROP && tq_cnt_reg == prop_len - 5'h01
         && run_ok) |=> (seg_reg == SEG_PH1)
    ) else $error("propagation segment did not end after its length");

    a_sample_in_ph1: assert property ( // [R5]
        sample_pulse_reg |-> ($past(seg_reg) == SEG_PH1 && seg_reg == SEG_PH2)
    ) else $error("sample taken away from end of phase 1");

    a_majority_vote: assert property ( // [R8]
        (ce && sample_now && cfg.triple_sample_sel && rx_in == samp_reg[0]
         && samp_reg[0] != samp_reg[1]) |=> (rx_bit_reg == $past(rx_in))
    ) else $error("majority sample resolved wrongly");

    a_ph2_auto_len: assert property ( // [R6]
        cfg.phase2_auto_sel |-> (ph2_base >= PROC_TIME_TQ && ph2_base >= ph1_base
                                 && (ph2_base == ph1_base || ph2_base == PROC_TIME_TQ))
    ) else $error("derived phase 2 length wrong");

    a_hsync_restart: assert property ( // [R11]
        hard_sync_now |=> (seg_reg == SEG_SYNC && tq_cnt_reg == 5'h00 && hard_sync_reg)
    ) else $error("hard sync did not restart the bit");

    a_no_resync_hsync: assert property ( // [R12]
        (hsync_bit_reg && !restart) |-> !(resync_late || resync_early)
    ) else $error("resync in a bit with hard sync");

    a_sjw_bound: assert property ( // [R13]
        (ph1_ext_reg <= sjw_len) && (ph2_cut_reg <= sjw_len)
    ) else $error("phase adjustment beyond jump width");

    a_late_lengthens: assert property ( // [R10]
        (ce && resync_late && !restart) |=> (ph1_ext_reg != 5'h00 && resync_reg)
    ) else $error("late edge did not lengthen phase 1");

    c_hard_sync: cover property (hard_sync_now ##1 (seg_reg == SEG_SYNC));
    c_late_resync: cover property (resync_late ##[1:200] sample_now);
    c_early_cut: cover property (resync_early && !early_restart);
    c_triple_sample: cover property (sample_now && cfg.triple_sample_sel);

endmodule

/* rtl/can_bt_pkg.sv */
// Shared constants and types of the bus bit timing engine
package can_bt_pkg;

    // ==================================================
    // Field positions in timing_config_1
    // ==================================================
    localparam int PRESCALE_LSB  = 0;
    localparam int PRESCALE_W    = 6;
    localparam int SJW_LSB       = 6;
    localparam int SJW_W         = 2;

    // ==================================================
    // Field positions in timing_config_2
    // ==================================================
    localparam int PROP_LSB      = 0;
    localparam int PH1_LSB       = 3;
    localparam int TRIPLE_BIT    = 6;
    localparam int PH2_AUTO_BIT  = 7;
    localparam int PH2_LSB       = 8;
    localparam int SEG_FIELD_W   = 3;

    // ==================================================
    // Values after reset and quantum counts
    // ==================================================
    localparam logic [15:0] TIMING_CONFIG_RESET = 16'h0000;
    localparam logic [4:0]  SYNC_SEG_TQ         = 5'h01;
    localparam logic [4:0]  PROC_TIME_TQ        = 5'h02;
    localparam logic [4:0]  MIN_BIT_TQ          = 5'h08;
    localparam logic [4:0]  MAX_BIT_TQ          = 5'h19;
    localparam logic        RECESSIVE           = 1'b1;

    // ==================================================
    // Types
    // ==================================================
    typedef logic [4:0] len_t;

    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_PROP,
        SEG_PH1,
        SEG_PH2
    } seg_state_t;

    // Decoded timing fields
    typedef struct packed {
        logic [PRESCALE_W-1:0]  quantum_prescale;
        logic [SJW_W-1:0]       sync_jump_width;
        logic [SEG_FIELD_W-1:0] prop_seg_len;
        logic [SEG_FIELD_W-1:0] phase1_len;
        logic [SEG_FIELD_W-1:0] phase2_len;
        logic                   triple_sample_sel;
        logic                   phase2_auto_sel;
    } timing_cfg_t;

    // Engine status toward the protocol logic
    typedef struct packed {
        seg_state_t seg;
        logic       rx_bit;
        logic       quantum_pulse;
        logic       sample_pulse;
        logic       bit_start;
        logic       hard_sync;
        logic       resync;
        logic       cfg_error;
    } bit_status_t;

endpackage

/* rtl/tq_prescaler.sv */
// Time quantum generator: programmable divider plus fixed divide by two
`timescale 1ns/1ps
module tq_prescaler #(
    parameter int PRESCALE_W = 6
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    // Control
    input  wire logic [PRESCALE_W-1:0] prescale,
    input  wire logic                  restart,
    // Ticks
    output logic                       half_tick,
    output logic                       tq_tick
);
    import can_bt_pkg::*;

    logic [PRESCALE_W-1:0] div_cnt_reg;
    logic                  phase_reg;

    // Half quantum every prescale+1 clocks, quantum every second one
    assign half_tick = ce && !restart && (div_cnt_reg == prescale); // [R3]
    assign tq_tick   = half_tick && phase_reg;                      // [R3]

    // Divider; a restart realigns the quantum to the edge that caused it
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            div_cnt_reg <= '0;
            phase_reg   <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                div_cnt_reg <= '0;
                phase_reg   <= 1'b0;
            end else if (half_tick) begin
                div_cnt_reg <= '0;
                phase_reg   <= !phase_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + 1'b1;
            end
        end
    end

    // ==================================================
    // Checks
    // ==================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic [PRESCALE_W:0]   gap_reg;
    logic                  gap_ok_reg;
    logic [PRESCALE_W-1:0] pre_seen_reg;

    // Cycles between half ticks, valid only over undisturbed stretches
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            gap_reg      <= '0;
            gap_ok_reg   <= 1'b0;
            pre_seen_reg <= '0;
        end else begin
            pre_seen_reg <= prescale;
            if (!ce || restart || pre_seen_reg != prescale) begin
                gap_ok_reg <= 1'b0;
                gap_reg    <= '0;
            end else if (half_tick) begin
                gap_ok_reg <= 1'b1;
                gap_reg    <= '0;
            end else begin
                gap_reg    <= gap_reg + 1'b1;
            end
        end
    end

    a_half_spacing: assert property ( // [R3]
        (half_tick && gap_ok_reg) |-> (gap_reg == {1'b0, prescale})
    ) else $error("half quantum spacing differs from prescale+1");

    a_tq_alternate: assert property ( // [R3]
        tq_tick |=> (!tq_tick && !phase_reg)
    ) else $error("two quantum ticks without a half tick between");

endmodule

/* sim/can_node_model.sv */
// Far-side bus node: sends one byte-long frame onto a wired-AND bus
`timescale 1ns/1ps
module can_node_model (
    // Clock
    input  wire logic       ref_clk,
    // Frame request
    input  wire logic       go,
    input  wire logic [7:0] pattern,
    input  wire logic [7:0] bit_cyc,
    // Bus side
    output logic            tx_line,
    output logic            busy
);
    // Bus pulled recessive whenever the node is silent
    initial begin
        tx_line = 1'b1;
        busy    = 1'b0;
    end

    // Same nominal bit as the engine, skewed only when asked
    always @(posedge ref_clk) begin
        if (go && !busy) begin
            #1;
            busy = 1'b1;
            for (int i = 7; i >= 0; i--) begin
                tx_line = pattern[i];
                repeat (bit_cyc) @(posedge ref_clk);
                #1;
            end
            tx_line = 1'b1;
            busy    = 1'b0;
        end
    end
endmodule

/* sim/can_bit_timing_sync_tb.sv */
// Self-checking bench for the bit timing engine
`timescale 1ns/1ps
module can_bit_timing_sync_tb;
    import can_bt_pkg::*;
    // ==================================================
    // Wiring
    // ==================================================
    logic        ref_clk  = 1'b0;
    logic        resetn   = 1'b0;
    logic        ce       = 1'b1;
    logic [15:0] cfg1     = 16'h0000;
    logic [15:0] cfg2     = 16'h0000;
    logic        tb_rx    = 1'b1;
    logic        bus_idle = 1'b1;
    logic        go       = 1'b0;
    logic [7:0]  pat      = 8'h00;
    logic [7:0]  bcyc     = 8'h00;
    logic        node_tx;
    logic        node_busy;
    logic        rx_in;
    bit_status_t status;
    int          cyc = 0;
    int          n_res = 0;
    int          h, lag;
    int          bad_count = 0;
    int          n_compared = 0;

    // Wired-AND bus: dominant wins
    assign rx_in = tb_rx & node_tx;
    always #2.5 ref_clk = ~ref_clk;

    // Cycle count, resync pulses and hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (status.resync === 1'b1) n_res <= n_res + 1;
        if (cyc == 30000) begin
            bad_count++;
            test_done();
        end
    end

    can_bit_timing_sync dut (
        .ref_clk         (ref_clk),
        .resetn          (resetn),
        .ce              (ce),
        .timing_config_1 (cfg1),
        .timing_config_2 (cfg2),
        .rx_in           (rx_in),
        .bus_idle        (bus_idle),
        .status          (status)
    );
    can_node_model node (
        .ref_clk (ref_clk),
        .go      (go),
        .pattern (pat),
        .bit_cyc (bcyc),
        .tx_line (node_tx),
        .busy    (node_busy)
    );

    // ==================================================
    // Helpers
    // ==================================================
    task step();
        @(posedge ref_clk);
        #1;
    endtask
    task at(input int c);
        while (cyc < c) step();
    endtask
    task chk(input logic got, input logic exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // Pulse absent one cycle early, present at c
    task pulse_at(input bit bs, input int c);
        at(c - 1);
        chk(bs ? status.bit_start : status.sample_pulse, 1'b0, "pulse early");
        step();
        chk(bs ? status.bit_start : status.sample_pulse, 1'b1, "pulse missing");
    endtask
    // Bits stay at 1 us or more except the refused 7-quanta case, prop+ph1 >= ph2 > jump width
    task set_cfg(input int p, sj, pr, p1, p2, au, tr);
        cfg1 = {8'h00, 2'(sj), 6'(p)};
        cfg2 = {5'h00, 3'(p2), 1'(au), 1'(tr), 3'(p1), 3'(pr)};
    endtask
    // Hard sync from idle; lag is engine delay behind the drive
    task hsync();
        int d;
        tb_rx = 1'b1;
        bus_idle = 1'b1;
        repeat (4) step();
        tb_rx = 1'b0;
        d = cyc;
        repeat (6) begin
            step();
            if (status.hard_sync === 1'b1) break;
        end
        h = cyc;
        lag = h - d;
        chk(status.hard_sync, 1'b1, "no hard sync");
        chk(status.bit_start, 1'b1, "no restart");
        bus_idle = 1'b0;
        n_res = 0;
    endtask
    task test_done();
        $display("Checks %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==================================================
    // Scenarios
    // ==================================================
    task t_reset();
        chk(status.seg == SEG_SYNC, 1'b1, "seg in reset");
        set_cfg(0, 0, 0, 2, 1, 0, 0);
        step();
        chk(status.cfg_error, 1'b1, "7 quanta taken");
        set_cfg(12, 0, 0, 2, 2, 0, 0);
        step();
        chk(status.cfg_error, 1'b0, "8 quanta refused");
    endtask
    // Table: minimum and maximum bit, derived phase 2, top prescale
    task t_seg();
        int p[5]  = '{12, 3, 11, 6, 63};
        int pr[5] = '{0, 7, 4, 1, 1};
        int p1[5] = '{2, 7, 0, 5, 1};
        int p2[5] = '{2, 7, 7, 0, 2};
        int au[5] = '{0, 0, 1, 1, 0};
        int q, ph2;
        for (int i = 0; i < 5; i++) begin
            set_cfg(p[i], 0, pr[i], p1[i], p2[i], au[i], 0);
            hsync();
            q = 2 * (p[i] + 1);
            ph2 = au[i] ? ((p1[i] > 0) ? p1[i] + 1 : 2) : p2[i] + 1;
            pulse_at(0, h + q * (pr[i] + p1[i] + 3));
            pulse_at(1, h + q * (pr[i] + p1[i] + ph2 + 3));
        end
    endtask
    // First tick shows quantum pulse and PROP; 40 frozen cycles delay the sample
    task t_freeze();
        set_cfg(7, 0, 3, 2, 4, 0, 0);
        hsync();
        at(h + 16);
        chk(status.quantum_pulse, 1'b1, "quantum pulse");
        chk(status.seg == SEG_PROP, 1'b1, "seg after sync");
        at(h + 40);
        ce = 1'b0;
        at(h + 80);
        ce = 1'b1;
        pulse_at(0, h + 168);
    endtask
    // Short recessive glitch around the sample point, quantum 16
    task t_triple(input int tr, input int up, input logic exp);
        set_cfg(7, 0, 3, 2, 4, 0, tr);
        hsync();
        at(h + up);
        tb_rx = 1'b1;
        at(h + 131);
        tb_rx = 1'b0;
        chk(status.rx_bit, exp, "sampled value");
        at(h + 140);
        chk(n_res == 0, 1'b1, "resync in hard sync bit");
    endtask
    // Edge early in phase 1: ignored in sync bit, later stretches by jump width
    task t_late(input int sj);
        set_cfg(7, sj, 3, 2, 4, 0, 0);
        hsync();
        at(h + 30);
        tb_rx = 1'b1;
        at(h + 90);
        tb_rx = 1'b0;
        pulse_at(0, h + 128);
        chk(n_res == 0, 1'b1, "resync in hard sync bit");
        at(h + 230);
        tb_rx = 1'b1;
        at(h + 504);
        tb_rx = 1'b0;
        pulse_at(0, h + 544 + 16 * (sj + 1));
        chk(n_res == 1, 1'b1, "resync count");
    endtask
    // Edge in phase 2 with four quanta left: shorten by one, or restart
    task t_early(input int sj);
        int c;
        // Let a stretched phase 1 clear before the jump width shrinks
        while (status.bit_start !== 1'b1) step();
        set_cfg(7, sj, 3, 2, 4, 0, 0);
        hsync();
        at(h + 30);
        tb_rx = 1'b1;
        at(h + 568);
        tb_rx = 1'b0;
        c = (sj == 0) ? h + 608 : h + 568 + lag;
        pulse_at(1, c);
        pulse_at(1, c + 208);
    endtask
    // Frame from the far node at equal, slower and faster bit rates
    task t_frame(input logic [7:0] bc);
        set_cfg(7, 1, 3, 2, 4, 0, 0); // Sample at 8 of 13 quanta
        tb_rx = 1'b1;
        bus_idle = 1'b1;
        pat = 8'h53;
        bcyc = bc;
        go = 1'b1;
        step();
        go = 1'b0;
        repeat (8) step();
        bus_idle = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            repeat (300) begin
                step();
                if (status.sample_pulse === 1'b1) break;
            end
            chk(status.rx_bit, pat[i], "frame bit");
        end
        while (node_busy) step();
    endtask

    initial begin
        repeat (10) step();
        t_reset();
        resetn = 1'b1;
        repeat (2) step();
        t_seg();
        t_freeze();
        t_triple(0, 124, 1'b1);
        t_triple(1, 124, 1'b0);
        t_triple(1, 114, 1'b1);
        for (int s = 0; s < 4; s++) t_late(s);
        t_early(0);
        t_early(3);
        t_frame(8'hD0);
        t_frame(8'hD4);
        t_frame(8'hCC);
        test_done();
    end
endmodule
